//--- hw/motor_starter_modbus_slave_regs.sv
// serial rtu slave of a motor soft-starter: line receiver and transmitter,
// telegram decode, coils, holding and input registers, nonvolatile save/load.
// assumes rx_in synchronous to core_clk, nvm load data valid at reset release.
// Behaviour
// - selectors sampled once after power-up only
// - address is tens times ten plus units
// - eight selectable line rates, master matches
// - characters are 8 data, no parity, 2 stop
// - functions 03 04 05 06 10 implemented
// - save command copies configuration to nonvolatile memory
// - power-up loads stored configuration into holding registers
// - no reception for 50 ms during save
// - coil 0 switches clockwise running
// - coil 1 switches anticlockwise running
// - command word a: reset and save bits
// - command word b: clockwise and anticlockwise bits
// - holding 2 is nominal motor current
// - holding 3 is start voltage percent
// - holding 4 is start ramp time
// - holding 5 is stop voltage percent
// - holding 6 is stop ramp time
// - holding 7/8 timeout enable and period
// - input 0 reports fault code
// - input 1 reports device state
// - input 2 reports measured current
// - input 3 reports load percent
`timescale 1ns/10ps
`include "motor_starter_defs.svh"
module motor_starter_modbus_slave_regs
  import motor_starter_pkg::*;
#(
  parameter int unsigned CORE_CLK_HZ       = `CLK_HZ,
  parameter int unsigned SAVE_BLOCK_CYCLES = `SAVE_BLOCK_CYCLES,
  parameter int unsigned MS_CYCLES         = `MS_CYCLES,
  parameter int unsigned RX_DEPTH          = 32,
  parameter int unsigned TX_DEPTH          = 32
)
(
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic [3:0]  address_tens_selector,
  input  wire logic [3:0]  address_units_selector,
  input  wire logic [2:0]  baud_selector,
  input  wire logic        rx_in,
  output      logic        tx_out,
  output      logic        tx_enable,
  input  wire config_t     nvm_load_data,
  input  wire logic        nvm_load_ok,
  output      logic        nvm_write,
  output      config_t     nvm_write_data,
  input  wire status_t     status_in,
  output      logic        run_clockwise,
  output      logic        run_anticlockwise,
  output      logic        device_reset,
  output      config_t     config_out
);
  localparam int BW = $clog2(SAVE_BLOCK_CYCLES + 1);
  localparam int MW = $clog2(MS_CYCLES + 1);

  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++)
      r = r[0] ? ((r >> 1) ^ `CRC_POLY) : (r >> 1);
    return r;
  endfunction

  frame_state_t fs;
  rx_state_t    rx_state;
  logic        init_done;
  logic [7:0]  slave_addr;
  logic        addr_ok;
  logic [2:0]  baud_sel;
  logic        nvm_fault;
  logic        comm_fault;
  logic [15:0] hold [9];
  logic [7:0]  rxb [RX_DEPTH];
  logic [7:0]  txb [TX_DEPTH];
  logic [5:0]  rx_cnt;
  logic [15:0] rx_crc;
  logic [17:0] bit_div;
  logic [17:0] tick_cnt;
  logic [5:0]  gap_cnt;
  logic [17:0] rx_timer;
  logic [2:0]  rx_bit;
  logic [7:0]  rx_shift;
  logic        rx_byte_valid;
  logic [3:0]  idx;
  logic [5:0]  tx_len;
  logic [5:0]  tx_ptr;
  logic        tx_active;
  logic [3:0]  tx_bitn;
  logic [17:0] tx_timer;
  logic [10:0] tx_shift;
  logic [15:0] tx_crc;
  logic [BW-1:0] block_cnt;
  logic [MW-1:0] ms_cnt;
  logic [15:0] watch_ms;

  // line rate follows the selector captured at power-up
  always_comb
  begin
    case (baud_sel)
      3'h0: bit_div = 18'(CORE_CLK_HZ / `BAUD_0);
      3'h1: bit_div = 18'(CORE_CLK_HZ / `BAUD_1);
      3'h2: bit_div = 18'(CORE_CLK_HZ / `BAUD_2);
      3'h3: bit_div = 18'(CORE_CLK_HZ / `BAUD_3);
      3'h4: bit_div = 18'(CORE_CLK_HZ / `BAUD_4);
      3'h5: bit_div = 18'(CORE_CLK_HZ / `BAUD_5);
      3'h6: bit_div = 18'(CORE_CLK_HZ / `BAUD_6);
      default: bit_div = 18'(CORE_CLK_HZ / `BAUD_7);
    endcase
  end

  // telegram fields
  wire [7:0]  fr_addr    = rxb[0];
  wire [7:0]  fr_fc      = rxb[1];
  wire [15:0] fr_start   = {rxb[2], rxb[3]};
  wire [15:0] fr_val     = {rxb[4], rxb[5]};
  wire        fc_read_h  = fr_fc == `FC_READ_HOLD;
  wire        fc_read_i  = fr_fc == `FC_READ_INPUT;
  wire        fc_coil    = fr_fc == `FC_WRITE_COIL;
  wire        fc_single  = fr_fc == `FC_WRITE_HOLD;
  wire        fc_multi   = fr_fc == `FC_WRITE_MULTI;
  wire        fc_read    = fc_read_h | fc_read_i;
  wire        fc_known   = fc_read | fc_coil | fc_single | fc_multi;
  wire [15:0] fr_qty     = (fc_coil | fc_single) ? 16'h0001 : fr_val;
  wire [16:0] fr_end     = {1'b0, fr_start} + {1'b0, fr_qty};
  wire [16:0] fr_limit   = fc_coil ? `NUM_COILS : fc_read_i ? `NUM_INPUT : `NUM_HOLD;
  wire        multi_len  = rx_cnt == `MULTI_OVERHEAD + {fr_val[4:0], 1'b0};
  wire        range_ok   = fr_qty != 16'h0000 && fr_end <= fr_limit;
  wire        value_ok   = fc_coil ? (fr_val == `COIL_ON || fr_val == `COIL_OFF)
                         : fc_multi ? multi_len : 1'b1;
  wire        broadcast  = fr_addr == `BCAST_ADDR;
  wire        frame_mine = rx_cnt >= `MIN_FRAME && rx_crc == 16'h0000
                           && (broadcast || (addr_ok && fr_addr == slave_addr));
  wire [7:0]  exc_code   = !fc_known ? `EXC_FUNC : !range_ok ? `EXC_ADDR
                         : !value_ok ? `EXC_VALUE : 8'h00;
  wire        gap_done   = gap_cnt == `GAP_BITS;
  wire        bit_tick   = tick_cnt == 18'h00000;
  wire        blocking   = block_cnt != '0;
  wire        ms_tick    = ms_cnt == '0;
  wire        rx_store   = rx_byte_valid && fs == FS_RECV && !blocking
                           && rx_cnt != 6'(RX_DEPTH);

  // one register per exec cycle
  wire [3:0]  cur_addr   = fr_start[3:0] + idx;
  wire        last_item  = {12'h000, idx} == fr_qty - 16'h0001;
  wire [4:0]  wr_ptr     = `MULTI_DATA_BASE + {idx, 1'b0};
  wire [15:0] wr_data    = fc_multi ? {rxb[wr_ptr], rxb[wr_ptr + 5'h01]} : fr_val;
  wire        exec       = fs == FS_EXEC;
  wire        hold_wr    = exec && (fc_single || fc_multi);
  wire        coil_wr    = exec && fc_coil;
  wire        coil_on    = fr_val == `COIL_ON;
  wire        cmd_a_wr   = hold_wr && cur_addr == `HOLD_CMD_A;
  wire        save_req   = (cmd_a_wr && wr_data[`CMD_SAVE_BIT])
                           || (coil_wr && cur_addr == `COIL_SAVE && coil_on);
  wire        reset_req  = (cmd_a_wr && wr_data[`CMD_RESET_BIT])
                           || (coil_wr && cur_addr == `COIL_RESET && coil_on);
  wire        save_go    = save_req && !blocking;
  wire [15:0] fault_rep  = comm_fault ? `FAULT_COMM : nvm_fault ? `FAULT_NVM
                         : status_in.fault_code;
  wire [15:0] state_rep  = nvm_fault ? `STATE_ERROR : status_in.device_state;
  wire [15:0] hold_rd    = cur_addr < 4'h9 ? hold[cur_addr] : 16'h0000;
  wire [15:0] input_rd   = cur_addr[1:0] == 2'h0 ? fault_rep
                         : cur_addr[1:0] == 2'h1 ? state_rep
                         : cur_addr[1:0] == 2'h2 ? status_in.motor_current
                         : status_in.load_percent;
  wire [15:0] rd_data    = fc_read_i ? input_rd : hold_rd;
  wire [7:0]  tx_byte    = tx_ptr < tx_len ? txb[tx_ptr[4:0]]
                         : tx_ptr == tx_len ? tx_crc[7:0] : tx_crc[15:8];
  // holding 2..8 form the stored configuration
  wire config_t cur_config = {hold[2], hold[3], hold[4], hold[5], hold[6], hold[7], hold[8]};

  assign config_out = cur_config;
  assign tx_out     = tx_shift[0];
  assign tx_enable  = fs == FS_SEND;

  // power-up capture; selectors are never looked at again
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      init_done  <= 1'b0;
      slave_addr <= 8'h00;
      addr_ok    <= 1'b0;
      baud_sel   <= 3'h0;
      nvm_fault  <= 1'b0;
    end
    else if (!init_done)
    begin
      init_done  <= 1'b1;
      slave_addr <= 8'(address_tens_selector * `TENS_WEIGHT + address_units_selector);
      addr_ok    <= address_tens_selector <= `DIGIT_MAX && address_units_selector <= `DIGIT_MAX
                    && (address_tens_selector != 4'h0 || address_units_selector != 4'h0);
      baud_sel   <= baud_selector;
      nvm_fault  <= !nvm_load_ok;
    end
  end

  // bit-time tick and silence detection between telegrams
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      tick_cnt <= 18'h00000;
      gap_cnt  <= 6'h00;
    end
    else
    begin
      tick_cnt <= bit_tick ? bit_div - 18'h00001 : tick_cnt - 18'h00001;
      if (rx_state != RX_IDLE || !rx_in)
        gap_cnt <= 6'h00;
      else if (bit_tick && !gap_done)
        gap_cnt <= gap_cnt + 6'h01;
    end
  end

  // receiver: samples mid-bit, checks the first stop bit only
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      rx_state      <= RX_IDLE;
      rx_timer      <= 18'h00000;
      rx_bit        <= 3'h0;
      rx_shift      <= 8'h00;
      rx_byte_valid <= 1'b0;
    end
    else
    begin
      rx_byte_valid <= 1'b0;
      if (rx_state != RX_IDLE && rx_timer != 18'h00000)
        rx_timer <= rx_timer - 18'h00001;
      else
        case (rx_state)
          RX_IDLE:
            if (!rx_in)
            begin
              rx_timer <= bit_div >> 1;
              rx_state <= RX_START;
            end
          RX_START:
          begin
            rx_timer <= bit_div - 18'h00001;
            rx_bit   <= 3'h0;
            rx_state <= rx_in ? RX_IDLE : RX_DATA;
          end
          RX_DATA:
          begin
            rx_shift <= {rx_in, rx_shift[7:1]};
            rx_timer <= bit_div - 18'h00001;
            rx_bit   <= rx_bit + 3'h1;
            if (rx_bit == `CHAR_DATA_BITS)
              rx_state <= RX_STOP;
          end
          RX_STOP:
          begin
            rx_byte_valid <= rx_in;
            rx_state      <= RX_IDLE;
          end
          default: rx_state <= RX_IDLE;
        endcase
    end
  end

  // telegram buffer; bytes arriving while a save runs are dropped
  always_ff @(posedge core_clk)
  begin
    if (!resetn || (fs == FS_CHECK))
    begin
      rx_cnt <= 6'h00;
      rx_crc <= `CRC_INIT;
    end
    else if (rx_store)
    begin
      rxb[rx_cnt[4:0]] <= rx_shift;
      rx_cnt           <= rx_cnt + 6'h01;
      rx_crc           <= crc_byte(rx_crc, rx_shift);
    end
  end

  // frame sequencer; a reply is only sent for a unicast telegram
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      fs     <= FS_RECV;
      idx    <= 4'h0;
      tx_len <= 6'h00;
    end
    else
      case (fs)
        FS_RECV:
          if (gap_done && rx_cnt != 6'h00 && rx_state == RX_IDLE)
            fs <= FS_CHECK;
        FS_CHECK:
        begin
          idx    <= 4'h0;
          tx_len <= exc_code != 8'h00 ? 6'h03 : fc_read ? 6'h03 + {fr_qty[4:0], 1'b0} : 6'h06;
          if (!frame_mine || (broadcast && (fc_read || exc_code != 8'h00)))
            fs <= FS_RECV;
          else if (exc_code != 8'h00)
            fs <= FS_SEND;
          else
            fs <= FS_EXEC;
        end
        FS_EXEC:
        begin
          idx <= idx + 4'h1;
          if (last_item)
            fs <= broadcast ? FS_RECV : FS_SEND;
        end
        FS_SEND:
          if (!tx_active && tx_ptr == tx_len + 6'h02)
            fs <= FS_RECV;
        default: fs <= FS_RECV;
      endcase
  end

  // reply buffer: header at check, read data during exec
  always_ff @(posedge core_clk)
  begin
    if (fs == FS_CHECK)
    begin
      txb[0] <= fr_addr;
      txb[1] <= exc_code != 8'h00 ? (fr_fc | `EXC_FLAG) : fr_fc;
      txb[2] <= exc_code != 8'h00 ? exc_code : fc_read ? {fr_qty[6:0], 1'b0} : rxb[2];
      txb[3] <= rxb[3];
      txb[4] <= rxb[4];
      txb[5] <= rxb[5];
    end
    else if (exec && fc_read)
    begin
      txb[5'h03 + {idx, 1'b0}] <= rd_data[15:8];
      txb[5'h04 + {idx, 1'b0}] <= rd_data[7:0];
    end
  end

  // transmitter: start bit, 8 data lsb first, two stop bits, crc low first
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      tx_ptr    <= 6'h00;
      tx_active <= 1'b0;
      tx_bitn   <= 4'h0;
      tx_timer  <= 18'h00000;
      tx_shift  <= 11'h7ff;
      tx_crc    <= `CRC_INIT;
    end
    else if (fs != FS_SEND)
    begin
      tx_ptr <= 6'h00;
      tx_crc <= `CRC_INIT;
    end
    else if (!tx_active)
    begin
      if (tx_ptr != tx_len + 6'h02)
      begin
        tx_shift  <= {2'b11, tx_byte, 1'b0};
        tx_active <= 1'b1;
        tx_bitn   <= 4'h0;
        tx_timer  <= bit_div - 18'h00001;
        if (tx_ptr < tx_len)
          tx_crc <= crc_byte(tx_crc, tx_byte);
      end
    end
    else if (tx_timer != 18'h00000)
      tx_timer <= tx_timer - 18'h00001;
    else
    begin
      tx_shift <= {1'b1, tx_shift[10:1]};
      tx_timer <= bit_div - 18'h00001;
      tx_bitn  <= tx_bitn + 4'h1;
      if (tx_bitn == `CHAR_LAST_BIT)
      begin
        tx_active <= 1'b0;
        tx_ptr    <= tx_ptr + 6'h01;
      end
    end
  end

  // holding registers: zero at reset, stored set loaded once after release
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      for (int i = 0; i < 9; i++)
        hold[i] <= 16'h0000;
    end
    else if (!init_done)
    begin
      if (nvm_load_ok)
        {hold[2], hold[3], hold[4], hold[5], hold[6], hold[7], hold[8]} <= nvm_load_data;
    end
    else if (hold_wr)
      hold[cur_addr] <= wr_data;
    else if (coil_wr && cur_addr == `COIL_RUN_CW)
      hold[`HOLD_CMD_B][`CMD_CW_BIT] <= coil_on;
    else if (coil_wr && cur_addr == `COIL_RUN_ACW)
      hold[`HOLD_CMD_B][`CMD_ACW_BIT] <= coil_on;
  end

  // save starts a nonvolatile write and a 50 ms receive blackout
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      block_cnt      <= '0;
      nvm_write      <= 1'b0;
      nvm_write_data <= '0;
      device_reset   <= 1'b0;
    end
    else
    begin
      nvm_write    <= save_go;
      device_reset <= reset_req;
      if (save_go)
      begin
        nvm_write_data <= cur_config;
        block_cnt      <= BW'(SAVE_BLOCK_CYCLES);
      end
      else if (blocking)
        block_cnt <= block_cnt - BW'(1);
    end
  end

  // link watchdog counts whole milliseconds since the last telegram for us
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      ms_cnt     <= '0;
      watch_ms   <= 16'h0000;
      comm_fault <= 1'b0;
    end
    else
    begin
      ms_cnt <= ms_tick ? MW'(MS_CYCLES - 1) : ms_cnt - MW'(1);
      if (fs == FS_CHECK && frame_mine)
        watch_ms <= 16'h0000;
      else if (ms_tick && watch_ms != 16'hffff)
        watch_ms <= watch_ms + 16'h0001;
      // a new timeout outranks a reset arriving in the same cycle
      if (hold[`HOLD_WATCH_EN] == 16'h0001 && watch_ms >= hold[`HOLD_WATCH_PERIOD])
        comm_fault <= 1'b1;
      else if (reset_req)
        comm_fault <= 1'b0;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      run_clockwise     <= 1'b0;
      run_anticlockwise <= 1'b0;
    end
    else
    begin
      run_clockwise     <= hold[`HOLD_CMD_B][`CMD_CW_BIT] && !comm_fault && !nvm_fault;
      run_anticlockwise <= hold[`HOLD_CMD_B][`CMD_ACW_BIT] && !comm_fault && !nvm_fault;
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);

  property p_select_once;
    init_done |=> $stable(slave_addr) && $stable(baud_sel);
  endproperty
  a_select_once: assert property (p_select_once) else $error("selector capture moved");

  property p_addr_form;
    !init_done |=> slave_addr == 8'($past(address_tens_selector) * `TENS_WEIGHT
                                    + $past(address_units_selector));
  endproperty
  a_addr_form: assert property (p_addr_form) else $error("slave address wrong");

  property p_stop_bits;
    tx_active && tx_bitn >= `CHAR_STOP_FIRST |-> tx_out;
  endproperty
  a_stop_bits: assert property (p_stop_bits) else $error("stop bit low");

  property p_exc_func;
    fs == FS_CHECK && frame_mine && !broadcast && !fc_known
      |=> fs == FS_SEND && txb[1] == ($past(fr_fc) | `EXC_FLAG) && txb[2] == `EXC_FUNC;
  endproperty
  a_exc_func: assert property (p_exc_func) else $error("bad function not refused");

  property p_save_write;
    save_go |=> nvm_write && nvm_write_data == $past(cur_config) ##1 !nvm_write;
  endproperty
  a_save_write: assert property (p_save_write) else $error("save not written");

  property p_block_rx;
    blocking && rx_byte_valid |=> rx_cnt == $past(rx_cnt) || fs != FS_RECV;
  endproperty
  a_block_rx: assert property (p_block_rx) else $error("byte taken during save");

  property p_coil_cw;
    coil_wr && cur_addr == `COIL_RUN_CW |=> hold[1][0] == $past(coil_on);
  endproperty
  a_coil_cw: assert property (p_coil_cw) else $error("clockwise coil ignored");

  property p_coil_acw;
    coil_wr && cur_addr == `COIL_RUN_ACW |=> hold[1][1] == $past(coil_on) ##1 !comm_fault
      && !nvm_fault |-> run_anticlockwise == $past(hold[1][1]);
  endproperty
  a_coil_acw: assert property (p_coil_acw) else $error("anticlockwise coil ignored");

  property p_comm_fault;
    comm_fault |-> fault_rep == `FAULT_COMM ##1 (!run_clockwise && !run_anticlockwise);
  endproperty
  a_comm_fault: assert property (p_comm_fault) else $error("timeout did not stop");

  property p_nvm_fault;
    init_done && nvm_fault |-> state_rep == `STATE_ERROR && (comm_fault || fault_rep == `FAULT_NVM);
  endproperty
  a_nvm_fault: assert property (p_nvm_fault) else $error("checksum fault not shown");

  c_save: cover property (save_go);
  c_multi: cover property (exec && fc_multi && last_item && !broadcast);
  c_reply: cover property ($fell(tx_enable));
endmodule

//--- shared/motor_starter_defs.svh
// constants of the motor starter serial slave: timing, codes, register map
// assumes a single 200 MHz core clock
`ifndef MOTOR_STARTER_DEFS_SVH
`define MOTOR_STARTER_DEFS_SVH
`define CLK_HZ            200000000
`define SAVE_BLOCK_MS     50
`define MS_CYCLES         (`CLK_HZ / 1000)
`define SAVE_BLOCK_CYCLES (`SAVE_BLOCK_MS * `MS_CYCLES)
`define BAUD_0            1200
`define BAUD_1            2400
`define BAUD_2            4800
`define BAUD_3            9600
`define BAUD_4            19200
`define BAUD_5            38400
`define BAUD_6            57600
`define BAUD_7            115200
`define CHAR_DATA_BITS    3'h7
`define CHAR_LAST_BIT     4'ha
`define CHAR_STOP_FIRST   4'h9
`define GAP_BITS          6'h27
`define FC_READ_HOLD      8'h03
`define FC_READ_INPUT     8'h04
`define FC_WRITE_COIL     8'h05
`define FC_WRITE_HOLD     8'h06
`define FC_WRITE_MULTI    8'h10
`define EXC_FUNC          8'h01
`define EXC_ADDR          8'h02
`define EXC_VALUE         8'h03
`define EXC_FLAG          8'h80
`define COIL_ON           16'hff00
`define COIL_OFF          16'h0000
`define COIL_RUN_CW       4'h0
`define COIL_RUN_ACW      4'h1
`define COIL_RESET        4'h2
`define COIL_SAVE         4'h3
`define NUM_COILS         17'h00004
`define NUM_HOLD          17'h00009
`define NUM_INPUT         17'h00004
`define HOLD_CMD_A        4'h0
`define HOLD_CMD_B        4'h1
`define HOLD_WATCH_EN     4'h7
`define HOLD_WATCH_PERIOD 4'h8
`define CMD_RESET_BIT     0
`define CMD_SAVE_BIT      1
`define CMD_CW_BIT        0
`define CMD_ACW_BIT       1
`define FAULT_COMM        16'h0009
`define FAULT_NVM         16'h000a
`define STATE_ERROR       16'h0006
`define ADDR_MAX          8'h63
`define DIGIT_MAX         4'h9
`define TENS_WEIGHT       8'h0a
`define BCAST_ADDR        8'h00
`define CRC_INIT          16'hffff
`define CRC_POLY          16'ha001
`define MIN_FRAME         6'h04
`define MULTI_OVERHEAD    6'h09
`define MULTI_DATA_BASE   5'h07
`endif

//--- shared/motor_starter_pkg.sv
// types shared by the motor starter serial slave
// constants live in motor_starter_defs.svh
package motor_starter_pkg;
  typedef struct packed {
    logic [15:0] nominal_current;
    logic [15:0] start_voltage;
    logic [15:0] start_ramp_time;
    logic [15:0] stop_voltage;
    logic [15:0] stop_ramp_time;
    logic [15:0] watch_enable;
    logic [15:0] watch_period;
  } config_t;
  typedef struct packed {
    logic [15:0] fault_code;
    logic [15:0] device_state;
    logic [15:0] motor_current;
    logic [15:0] load_percent;
  } status_t;
  typedef enum logic [1:0] {
    FS_RECV  = 2'b00,
    FS_CHECK = 2'b01,
    FS_EXEC  = 2'b10,
    FS_SEND  = 2'b11
  } frame_state_t;
  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b10,
    RX_STOP  = 2'b11
  } rx_state_t;
endpackage

//--- testbench/modbus_master_model.sv
// serial bus master model: sends rtu characters, samples reply characters
// assumes the slave is set to 115200 baud on a 200 MHz core clock
`timescale 1ns/10ps
module modbus_master_model
#(
  parameter int BIT_CYCLES = 1736
)
(
  input  wire logic core_clk,
  input  wire logic tx_out,
  output      logic rx_line
);
  initial rx_line = 1'b1;

  // start, 8 data lsb first, no parity, 2 stop
  task automatic send_byte(input logic [7:0] b);
    logic [10:0] sh;
    sh = {2'b11, b, 1'b0};
    for (int i = 0; i < 11; i++)
    begin
      rx_line <= sh[i];
      repeat (BIT_CYCLES) @(posedge core_clk);
    end
  endtask

  // bounded wait for a start bit, then mid-bit sampling
  task automatic recv_byte(output logic [7:0] b, output logic ok);
    int n;
    n = 0;
    b = 8'h00;
    while (tx_out !== 1'b0 && n < 100 * BIT_CYCLES)
    begin
      @(posedge core_clk);
      n++;
    end
    repeat (BIT_CYCLES / 2) @(posedge core_clk);
    for (int i = 0; i < 8; i++)
    begin
      repeat (BIT_CYCLES) @(posedge core_clk);
      b[i] = tx_out;
    end
    repeat (BIT_CYCLES) @(posedge core_clk);
    ok = (n < 100 * BIT_CYCLES) && (tx_out === 1'b1);
  endtask
endmodule

//--- testbench/testbench.sv
// self-checking bench of the motor starter serial slave
// assumes the master model on the link and fixed power-up selector settings
`timescale 1ns/10ps
`include "motor_starter_defs.svh"
module testbench;
  import motor_starter_pkg::*;
  logic       core_clk = 1'b0;
  logic       resetn   = 1'b0;
  logic [3:0] units    = 4'h5;
  logic       rx_in;
  logic       tx_out;
  logic       nvm_write;
  logic       run_cw;
  config_t    cfg;
  config_t    nvm_wdata;
  config_t    nvm_data = {16'h0064, 16'h001e, 16'h000a, 16'h0050, 16'h0014, 16'h0, 16'h03e8};
  status_t    status   = {16'h0000, 16'h0003, 16'h04d2, 16'h0041};
  int         n_fail   = 0;
  int         n_tests  = 0;
  int         n_save   = 0;
  // scaled clock figure keeps one bit at 10 cycles so the run stays short
  localparam int BIT = 10;

  always #2.5 core_clk = ~core_clk;
  always @(posedge core_clk) if (nvm_write === 1'b1) n_save <= n_save + 1;

  motor_starter_modbus_slave_regs #(.CORE_CLK_HZ(1152000), .SAVE_BLOCK_CYCLES(200),
                                    .MS_CYCLES(50))
  i_motor_starter_modbus_slave_regs (
    .core_clk(core_clk), .resetn(resetn), .address_tens_selector(4'h0),
    .address_units_selector(units), .baud_selector(3'h7), .rx_in(rx_in),
    .tx_out(tx_out), .tx_enable(), .nvm_load_data(nvm_data), .nvm_load_ok(1'b1),
    .nvm_write(nvm_write), .nvm_write_data(nvm_wdata), .status_in(status),
    .run_clockwise(run_cw), .run_anticlockwise(), .device_reset(), .config_out(cfg));

  modbus_master_model #(.BIT_CYCLES(BIT)) i_modbus_master_model (
    .core_clk(core_clk), .tx_out(tx_out), .rx_line(rx_in));

  task automatic wrap_up();
    $display("checks %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic logic [15:0] crc16(input logic [7:0] q[$]);
    logic [15:0] c;
    c = `CRC_INIT;
    foreach (q[i])
    begin
      c = c ^ {8'h00, q[i]};
      for (int k = 0; k < 8; k++)
        c = c[0] ? ((c >> 1) ^ `CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction

  // sends q with its crc, expects reply e with its crc
  task automatic xfer(input logic [7:0] q[$], input logic [7:0] e[$]);
    logic [15:0] c;
    logic [7:0]  b;
    logic        ok;
    c = crc16(q);
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
    c = crc16(e);
    e.push_back(c[7:0]);
    e.push_back(c[15:8]);
    foreach (q[i]) i_modbus_master_model.send_byte(q[i]);
    foreach (e[i])
    begin
      i_modbus_master_model.recv_byte(b, ok);
      chk({15'h0, ok}, 16'h0001);
      if (ok !== 1'b1)
        wrap_up();
      chk({8'h00, b}, {8'h00, e[i]});
    end
    // spacing keeps the next telegram clear of the reply's tail
    repeat (4 * BIT) @(posedge core_clk);
  endtask

  initial
  begin
    repeat (3) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (2) @(posedge core_clk);
    units <= 4'h6;
    chk(cfg.start_voltage, nvm_data.start_voltage);
    chk(cfg.watch_period, nvm_data.watch_period);
    xfer('{8'h05, 8'h06, 8'h00, 8'h04, 8'h00, 8'h32}, '{8'h05, 8'h06, 8'h00, 8'h04, 8'h00, 8'h32});
    chk(cfg.start_ramp_time, 16'h0032);
    xfer('{8'h05, 8'h05, 8'h00, 8'h00, 8'hff, 8'h00}, '{8'h05, 8'h05, 8'h00, 8'h00, 8'hff, 8'h00});
    chk({15'h0, run_cw}, 16'h0001);
    // one save only: the store wears out
    xfer('{8'h05, 8'h05, 8'h00, 8'h03, 8'hff, 8'h00}, '{8'h05, 8'h05, 8'h00, 8'h03, 8'hff, 8'h00});
    chk(n_save[15:0], 16'h0001);
    chk(nvm_wdata.start_ramp_time, 16'h0032);
    xfer('{8'h05, 8'h04, 8'h00, 8'h00, 8'h00, 8'h04},
         '{8'h05, 8'h04, 8'h08, 8'h00, 8'h00, 8'h00, 8'h03, 8'h04, 8'hd2, 8'h00, 8'h41});
    xfer('{8'h05, 8'h03, 8'h00, 8'h03, 8'h00, 8'h02}, '{8'h05, 8'h03, 8'h04, 8'h00, 8'h1e, 8'h00, 8'h32});
    xfer('{8'h05, 8'h01, 8'h00, 8'h00, 8'h00, 8'h01}, '{8'h05, 8'h81, 8'h01});
    xfer('{8'h05, 8'h05, 8'h00, 8'h00, 8'h00, 8'h00}, '{8'h05, 8'h05, 8'h00, 8'h00, 8'h00, 8'h00});
    chk({15'h0, run_cw}, 16'h0000);
    wrap_up();
  end
endmodule
